// ---- rtl/pm_cfg_params.svh ----
`ifndef PM_CFG_PARAMS_SVH
`define PM_CFG_PARAMS_SVH
`define ADDR_IRQ_ENABLE 8'hEC
`define ADDR_PERIPHERAL_CONFIG_STATUS 8'hF4
`define ADDR_ADC_START 8'hD8
`define ADDR_RETAINED_SCRATCH_ONE 8'hFB
`define ADDR_RETAINED_SCRATCH_TWO 8'hFC
`define ADDR_RETAINED_SCRATCH_THREE 8'hFD
`define ADDR_RETAINED_SCRATCH_FOUR 8'hFE
`define BIT_WAKE 7
`define BIT_SRC 6
`define BIT_VOK 5
`define BIT_PLL 4
`define BIT_REF 3
`define BIT_PLL_ACK 4
`define IRQ_EN_MASK 8'hAF
`define PERIPHERAL_CONFIG_STATUS_WR_MASK 8'h0B
`define PIN_GPIO 2'h0
`define PIN_RX_NOWAKE 2'h1
`define PIN_RX_WAKE 2'h3
`endif

// ---- rtl/pm_cfg_pkg.sv ----
package pm_cfg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    PIN_GPIO_E = 2'b00,
    PIN_RX_NOWAKE_E = 2'b01,
    PIN_RESERVED_E = 2'b10,
    PIN_RX_WAKE_E = 2'b11
  } pin_func_e;
  typedef struct packed {
    byte_t irq_en;
    logic wake_flag;
    logic pll_fault;
    logic ref_en;
    logic [1:0] pin_func;
    logic summary_flag;
    logic irq;
    byte_t rdata;
    logic pll_lock_d;
  } state_s;
endpackage

// ---- rtl/power_mgmt_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pm_cfg_params.svh"
module power_mgmt_config_regs
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic total_power_lossn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic rail_source_indicator_in,
  input wire logic main_supply_ok_in,
  input wire logic pll_locked_in,
  input wire logic deep_sleep_mode_in,
  input wire logic second_uart_receive_edge_in,
  input wire logic [5:0] source_flags_in,
  output logic [7:0] power_irq_enable_out,
  output logic sleep_reference_enable_out,
  output var pm_cfg_pkg::pin_func_e shared_pin_function_out,
  output logic power_irq_summary_flag_out,
  output logic power_irq_out
);
  import pm_cfg_pkg::*;
  // source_flags_in: 5 restored,4 sag,3 adc,2 battery,1 switchover,0 low
  state_s st_reg;
  state_s st_next;
  byte_t scratch_reg [4];
  logic [7:0] flags8;
  logic [7:0] pending;
  logic wr_en;
  logic wr_peripheral_config_status;
  logic wr_irq_en;
  logic wr_ack;

  // one address compare shared by the decode and the checks
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    return addr == target;
  endfunction

  // scratch window covers four consecutive addresses
  function automatic logic scratch_hit(input logic [7:0] addr);
    return addr >= `ADDR_RETAINED_SCRATCH_ONE && addr <= `ADDR_RETAINED_SCRATCH_FOUR;
  endfunction

  // map the six sources onto their enable bit positions
  always_comb
  begin
    flags8 = {source_flags_in[5], 1'b0, source_flags_in[4], 1'b0,
      source_flags_in[3:0]};
    pending = flags8 & st_reg.irq_en & `IRQ_EN_MASK;
    wr_en = sfr_wr_in;
    wr_peripheral_config_status = wr_en && addr_hit(sfr_addr_in, `ADDR_PERIPHERAL_CONFIG_STATUS);
    wr_irq_en = wr_en && addr_hit(sfr_addr_in, `ADDR_IRQ_ENABLE);
    wr_ack = wr_en && addr_hit(sfr_addr_in, `ADDR_ADC_START) && sfr_wdata_in[`BIT_PLL_ACK];
  end

  // all control state in one struct
  always_comb
  begin
    st_next = st_reg;
    st_next.pll_lock_d = pll_locked_in;
    if (wr_irq_en)
    begin
      // reserved bits forced low; software should write zero anyway
      st_next.irq_en = sfr_wdata_in & `IRQ_EN_MASK;
    end
    if (wr_peripheral_config_status)
    begin
      st_next.ref_en = sfr_wdata_in[`BIT_REF];
      st_next.pin_func = sfr_wdata_in[1:0];
      // writing zero clears the wake indication
      if (!sfr_wdata_in[`BIT_WAKE])
      begin
        st_next.wake_flag = 1'b0;
      end
    end
    // uart2 wake latch; set wins over clear
    if (second_uart_receive_edge_in && deep_sleep_mode_in
      && st_reg.pin_func == `PIN_RX_WAKE)
    begin
      st_next.wake_flag = 1'b1;
    end
    if (wr_ack)
    begin
      st_next.pll_fault = 1'b0;
    end
    if (st_reg.pll_lock_d && !pll_locked_in)
    begin
      st_next.pll_fault = 1'b1;
    end
    st_next.summary_flag = |pending;
    st_next.irq = |pending;
    st_next.rdata = 8'h00;
    if (sfr_rd_in)
    begin
      case (sfr_addr_in)
        `ADDR_IRQ_ENABLE: st_next.rdata = st_reg.irq_en;
        `ADDR_PERIPHERAL_CONFIG_STATUS: st_next.rdata = {st_reg.wake_flag, rail_source_indicator_in,
          main_supply_ok_in, st_reg.pll_fault, st_reg.ref_en, 1'b0, st_reg.pin_func};
        `ADDR_RETAINED_SCRATCH_ONE: st_next.rdata = scratch_reg[0];
        `ADDR_RETAINED_SCRATCH_TWO: st_next.rdata = scratch_reg[1];
        `ADDR_RETAINED_SCRATCH_THREE: st_next.rdata = scratch_reg[2];
        `ADDR_RETAINED_SCRATCH_FOUR: st_next.rdata = scratch_reg[3];
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_reg <= '0;
      st_reg.pll_lock_d <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // scratch pads sit on the always-on domain; core reset must not touch them
  // only total supply loss clears
  always_ff @(posedge clk_in or negedge total_power_lossn_in)
  begin
    if (!total_power_lossn_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        scratch_reg[i] <= 8'h00;
      end
    end
    else if (wr_en && scratch_hit(sfr_addr_in))
    begin
      scratch_reg[2'(sfr_addr_in - `ADDR_RETAINED_SCRATCH_ONE)] <= sfr_wdata_in;
    end
  end

  // outputs straight from flops
  assign sfr_rdata_out = st_reg.rdata;
  assign power_irq_enable_out = st_reg.irq_en;
  assign sleep_reference_enable_out = st_reg.ref_en;
  assign shared_pin_function_out = pin_func_e'(st_reg.pin_func);
  assign power_irq_summary_flag_out = st_reg.summary_flag;
  assign power_irq_out = st_reg.irq;

  // checks watch the registered outputs and the state struct, so a failure
  // points at this block and not at whoever drives it

  // interrupt request and summary flag
  // request follows enabled flag
  a_irq_follows: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (|(flags8 & power_irq_enable_out)) |=> power_irq_out)
    else $error("irq missing");

  a_irq_drops: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(|(flags8 & power_irq_enable_out)) |=> !power_irq_out)
    else $error("irq without enabled flag");

  a_irq_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (power_irq_enable_out == 8'h00) |=> !power_irq_out)
    else $error("irq without enable");

  a_restored_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[5] && power_irq_enable_out[7]) |=> power_irq_out)
    else $error("restored source lost");

  a_sag_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[4] && power_irq_enable_out[5]) |=> power_irq_out)
    else $error("sag source lost");

  a_adc_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[3] && power_irq_enable_out[3]) |=> power_irq_out)
    else $error("adc source lost");

  a_battery_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[2] && power_irq_enable_out[2]) |=> power_irq_out)
    else $error("battery source lost");

  a_switch_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[1] && power_irq_enable_out[1]) |=> power_irq_out)
    else $error("switchover source lost");

  a_low_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (source_flags_in[0] && power_irq_enable_out[0]) |=> power_irq_out)
    else $error("low voltage source lost");

  a_summary_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (|(flags8 & power_irq_enable_out)) |=> power_irq_summary_flag_out)
    else $error("summary flag missing");

  a_summary_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(|(flags8 & power_irq_enable_out)) |=> !power_irq_summary_flag_out)
    else $error("summary flag stuck");

  a_enable_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_irq_en |=> power_irq_enable_out == ($past(sfr_wdata_in) & `IRQ_EN_MASK))
    else $error("enable write wrong");

  a_enable_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !wr_irq_en |=> $stable(power_irq_enable_out))
    else $error("enable changed unasked");

  a_enable_rsvd: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (power_irq_enable_out & 8'h50) == 8'h00)
    else $error("reserved enable set");

  // pll fault latch
  // lock loss latches fault
  a_pll_latch: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ($fell(pll_locked_in) && $past(resetn_in)) |=> st_reg.pll_fault)
    else $error("pll fault not latched");

  a_pll_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_reg.pll_fault && !wr_ack) |=> st_reg.pll_fault)
    else $error("pll fault lost");

  a_pll_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!st_reg.pll_fault && !(st_reg.pll_lock_d && !pll_locked_in))
    |=> !st_reg.pll_fault)
    else $error("pll fault without loss");

  a_pll_ack: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_en && addr_hit(sfr_addr_in, `ADDR_ADC_START) && sfr_wdata_in[4]
    && pll_locked_in && st_reg.pll_lock_d) |=> !st_reg.pll_fault)
    else $error("pll fault not cleared");

  // wake indication
  // wake edge sets flag
  a_wake_set: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (second_uart_receive_edge_in && deep_sleep_mode_in && st_reg.pin_func == 2'b11)
    |=> st_reg.wake_flag)
    else $error("wake flag not set");

  a_wake_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (st_reg.wake_flag && !wr_peripheral_config_status) |=> st_reg.wake_flag)
    else $error("wake flag lost");

  a_wake_quiet: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!st_reg.wake_flag && !second_uart_receive_edge_in) |=> !st_reg.wake_flag)
    else $error("wake flag without edge");

  a_wake_clear: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (wr_peripheral_config_status && !sfr_wdata_in[7] && !second_uart_receive_edge_in)
    |=> !st_reg.wake_flag)
    else $error("wake flag not cleared");

  a_wake_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!st_reg.wake_flag && !deep_sleep_mode_in) |=> !st_reg.wake_flag)
    else $error("wake flag while awake");

  // configuration bits
  // reference bit written
  a_ref_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_peripheral_config_status |=> sleep_reference_enable_out == $past(sfr_wdata_in[3]))
    else $error("reference enable wrong");

  a_ref_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !wr_peripheral_config_status |=> $stable(sleep_reference_enable_out))
    else $error("reference enable changed");

  a_pin_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    wr_peripheral_config_status |=> shared_pin_function_out == $past(sfr_wdata_in[1:0]))
    else $error("pin function wrong");

  a_pin_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !wr_peripheral_config_status |=> $stable(shared_pin_function_out))
    else $error("pin function changed");

  // read path
  // rail source read live
  a_peripheral_config_status_src: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sfr_rd_in && addr_hit(sfr_addr_in, `ADDR_PERIPHERAL_CONFIG_STATUS))
    |=> sfr_rdata_out[6] == $past(rail_source_indicator_in))
    else $error("rail source wrong");

  a_peripheral_config_status_ok: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sfr_rd_in && addr_hit(sfr_addr_in, `ADDR_PERIPHERAL_CONFIG_STATUS))
    |=> sfr_rdata_out[5] == $past(main_supply_ok_in))
    else $error("supply ready wrong");

  a_peripheral_config_status_rsvd: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sfr_rd_in && addr_hit(sfr_addr_in, `ADDR_PERIPHERAL_CONFIG_STATUS)) |=> !sfr_rdata_out[2])
    else $error("reserved bit read high");

  a_rdata_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !sfr_rd_in |=> sfr_rdata_out == 8'h00)
    else $error("read data without strobe");

  a_enable_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (sfr_rd_in && addr_hit(sfr_addr_in, `ADDR_IRQ_ENABLE))
    |=> sfr_rdata_out == $past(power_irq_enable_out))
    else $error("enable read wrong");

  // retained scratch pads
  // scratch pad reads back
  a_scratch_read: assert property (@(posedge clk_in) disable iff (!resetn_in || !total_power_lossn_in)
    (sfr_rd_in && addr_hit(sfr_addr_in, `ADDR_RETAINED_SCRATCH_ONE))
    |=> sfr_rdata_out == $past(scratch_reg[0]))
    else $error("scratch read wrong");

  a_scratch_rw: assert property (@(posedge clk_in) disable iff (!total_power_lossn_in)
    (wr_en && addr_hit(sfr_addr_in, `ADDR_RETAINED_SCRATCH_TWO))
    |=> scratch_reg[1] == $past(sfr_wdata_in))
    else $error("scratch write lost");

  a_scratch_keep: assert property (@(posedge clk_in) disable iff (!total_power_lossn_in)
    !(wr_en && scratch_hit(sfr_addr_in))
    |=> $stable(scratch_reg[0]))
    else $error("scratch pad one changed");

  a_scratch_last: assert property (@(posedge clk_in) disable iff (!total_power_lossn_in)
    !(wr_en && scratch_hit(sfr_addr_in))
    |=> $stable(scratch_reg[3]))
    else $error("scratch pad four changed");
endmodule
`default_nettype wire

// ---- tb/power_mgmt_config_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_config_regs_tb_top;
  import pm_cfg_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic total_power_lossn_in = 1'b0;
  logic [7:0] sfr_addr_in = 8'h00;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic rail_in = 1'b1;
  logic ok_in = 1'b1;
  logic lock_in = 1'b1;
  logic sleep_in = 1'b0;
  logic edge_in = 1'b0;
  logic [5:0] flags_in = 6'h00;
  wire logic [7:0] rdata;
  wire logic [7:0] en_out;
  wire logic ref_out;
  pin_func_e pin_out;
  wire logic sum_out;
  wire logic irq_out;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [7:0] e;
  // free-running core clock, 10 ns
  always #5 clk_in = ~clk_in;
  power_mgmt_config_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in),
    .total_power_lossn_in(total_power_lossn_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(rdata), .rail_source_indicator_in(rail_in), .main_supply_ok_in(ok_in),
    .pll_locked_in(lock_in), .deep_sleep_mode_in(sleep_in),
    .second_uart_receive_edge_in(edge_in), .source_flags_in(flags_in),
    .power_irq_enable_out(en_out), .sleep_reference_enable_out(ref_out),
    .shared_pin_function_out(pin_out), .power_irq_summary_flag_out(sum_out),
    .power_irq_out(irq_out));
  // compare and count; an unknown bit matches only an unknown bit
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // strobes rise and fall on falling edges so the rising edge sees them settled
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    sfr_wr_in = 1'b1;
    sfr_addr_in = a;
    sfr_wdata_in = d;
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask
  // read data stands only the cycle after the strobe, so look then
  task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_in);
    sfr_rd_in = 1'b1;
    sfr_addr_in = a;
    @(negedge clk_in);
    sfr_rd_in = 1'b0;
    chk(what, rdata, exp);
  endtask
  task scr(input logic clr);
    for (int i = 0; i < 4; i++)
      rd(8'hFB + 8'(i), clr ? 8'h00 : 8'hA5 ^ 8'(i), "scratch");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(negedge clk_in);
    resetn_in = 1'b1;
    total_power_lossn_in = 1'b1;
    rd(8'hF4, 8'h60, "peripheral_config_status reset");
    rd(8'hEC, 8'h00, "enable reset");
    rd(8'h80, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++)
      wr(8'hFB + 8'(i), 8'hA5 ^ 8'(i));
    scr(1'b0);
    resetn_in = 1'b0;
    @(negedge clk_in);
    resetn_in = 1'b1;
    scr(1'b0);
    total_power_lossn_in = 1'b0;
    @(negedge clk_in);
    total_power_lossn_in = 1'b1;
    scr(1'b1);
    wr(8'hF4, 8'hFB);
    rd(8'hF4, 8'h6B, "peripheral_config_status wr");
    chk("ref", {7'h00, ref_out}, 8'h01);
    sleep_in = 1'b1;
    @(negedge clk_in);
    edge_in = 1'b1;
    @(negedge clk_in);
    edge_in = 1'b0;
    rd(8'hF4, 8'hEB, "wake");
    wr(8'hF4, 8'h0B);
    rd(8'hF4, 8'h6B, "wake clr");
    lock_in = 1'b0;
    @(negedge clk_in);
    lock_in = 1'b1;
    rd(8'hF4, 8'h7B, "pll");
    wr(8'hD8, 8'h10);
    rd(8'hF4, 8'h6B, "pll ack");
    rail_in = 1'b0;
    ok_in = 1'b0;
    rd(8'hF4, 8'h0B, "battery");
    foreach (e[i])
      if (i < 4 && i != 2)
      begin
        wr(8'hF4, 8'(i));
        chk("pin", {6'h00, pin_out}, 8'(i));
      end
    wr(8'hEC, 8'hEF);
    rd(8'hEC, 8'hAF, "enable mask");
    for (int i = 0; i < 6; i++)
    begin
      e = 8'h01 << (i + (i > 3) + (i > 4));
      wr(8'hEC, e);
      chk("en", en_out, e);
      flags_in = 6'(1 << i);
      repeat (2) @(negedge clk_in);
      chk("irq on", {6'h00, sum_out, irq_out}, 8'h03);
      flags_in = ~6'(1 << i);
      repeat (2) @(negedge clk_in);
      chk("irq off", {6'h00, sum_out, irq_out}, 8'h00);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
